// ---- hw/pmbus_onoff_consts.vh ----
// Purpose: Shared constants for the on/off, margin and write-lock command logic
// Assumes: Byte-wide command registers reached by command code
// Notes:   Definitions only
`ifndef PMBUS_ONOFF_CONSTS_VH
`define PMBUS_ONOFF_CONSTS_VH

// ==========================================================
// Command codes
`define CODE_RUN_MARGIN      8'h01
`define CODE_ENABLE_CONFIG   8'h02
`define CODE_CLEAR_FAULTS    8'h03
`define CODE_WRITE_LOCK      8'h10

// ==========================================================
// Run/margin register fields
`define RUN_BIT              7
`define MARGIN_HI            5
`define MARGIN_LO            2
`define RUN_MARGIN_KEEP      8'hBC
`define RUN_MARGIN_RESET     8'h00

// ==========================================================
// Margin select patterns
`define MARGIN_LOW_IGNORE    4'h5
`define MARGIN_LOW_ACT       4'h6
`define MARGIN_HIGH_IGNORE   4'h9
`define MARGIN_HIGH_ACT      4'hA

// ==========================================================
// Enable source configuration fields
`define CMD_USE_BIT          3
`define PIN_USE_BIT          2
`define CONFIG_KEEP          8'h0C
`define CONFIG_FIXED_ONES    8'h13
`define CONFIG_RESET         8'h17

// ==========================================================
// Write lock levels
`define LOCK_ALL             8'h80
`define LOCK_ALLOW_RUN       8'h40
`define LOCK_ALLOW_RUN_CFG   8'h20
`define LOCK_NONE            8'h00
`define LOCK_RESET           8'h00

// ==========================================================
// Fault latch layout
`define FAULT_COUNT          5
`define FAULT_CML            4

`endif

// ---- hw/write_gate.v ----
// Purpose: Decide whether a command write is allowed by the write lock level
// Assumes: Lock level register holds only defined codes
// Notes:   Pure combinational
`timescale 1ns/10ps
`default_nettype none
`include "pmbus_onoff_consts.vh"

module write_gate (
   input  wire [7:0] lock_level,
   input  wire [7:0] code,
   output reg        allowed
);

   // ==========================================================
   // Permission decode
   always @* begin
      allowed = 1'b0;
      if (code == `CODE_WRITE_LOCK) begin
         allowed = 1'b1;
      end else if (lock_level == `LOCK_NONE) begin
         allowed = 1'b1;
      end else if (lock_level == `LOCK_ALLOW_RUN) begin
         allowed = (code == `CODE_RUN_MARGIN);
      end else if (lock_level == `LOCK_ALLOW_RUN_CFG) begin
         allowed = (code == `CODE_RUN_MARGIN) || (code == `CODE_ENABLE_CONFIG);
      end else begin
         allowed = 1'b0;
      end
   end

endmodule // write_gate
`default_nettype wire

// ---- hw/fault_latch.v ----
// Purpose: Latched fault flags with alert drive and clear
// Assumes: Fault conditions are levels, events are one-cycle pulses
// Notes:   Set wins over clear so a standing fault reappears at once
`timescale 1ns/10ps
`default_nettype none
`include "pmbus_onoff_consts.vh"

module fault_latch (
   input  wire                      core_clk,
   input  wire                      rst_n,
   input  wire [`FAULT_COUNT-1:0]   fault_set,
   input  wire                      clear,
   output reg  [`FAULT_COUNT-1:0]   flags_r,
   output reg                       alert_r
);

   reg  [`FAULT_COUNT-1:0] flags_nxt;

   // ==========================================================
   // Flag update
   always @* begin
      flags_nxt = flags_r;
      if (clear) begin
         flags_nxt = {`FAULT_COUNT{1'b0}};
      end
      flags_nxt = flags_nxt | fault_set;
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         flags_r <= {`FAULT_COUNT{1'b0}};
         alert_r <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         // Alert follows the flags, released and re-raised in the same step
         alert_r <= |flags_nxt;
      end
   end

endmodule // fault_latch
`default_nettype wire

// ---- hw/pmbus_onoff_protect_regs.v ----
// Purpose: On/off, margin and write-lock command registers behind the serial slave
// Assumes: The serial front end delivers decoded byte commands, one per pulse
// Notes:   Reset stands for supply power-up
//          Every command is acknowledged; malformed or unknown ones only
//          raise the communication fault flag
//          The lock level never blocks clear-faults, which stores no register
//
// Operation
// - Codes 01h run/margin, 02h config, 10h lock
// - Run bit seven requests converter run or stop
// - Margin pattern 00xx keeps margining off
// - 0101 low ignore faults, 0110 low act
// - 1001 high ignore faults, 1010 high act
// - Unsupported bits ignore written values
// - Config bits four, one, zero read one
// - Config bit three selects run bit use
// - Pin only when pin-use alone set
// - Run bit only when command-use alone set
// - Both set needs pin and run bit
// - Neither set enables after address detection
// - Lock levels 80h, 40h, 20h restrict writes
// - Lock 00h allows all, others faulty
// - Clear-faults 03h clears all latched flags
// - Clear-faults releases alert simultaneously
// - Standing fault sets flags and alert again
// - Clear-faults never restarts latched-off converter
// - Restart by enable off-on or power cycle
// - Clear-faults carries no data byte
// - Communication faults set flag and alert
`timescale 1ns/10ps
`default_nettype none
`include "pmbus_onoff_consts.vh"

module pmbus_onoff_protect_regs (
   input  wire        core_clk,
   input  wire        rst_n,
   // Decoded command port from the serial front end
   input  wire        cmd_valid,
   input  wire [7:0]  cmd_code,
   input  wire        cmd_read,
   input  wire        cmd_has_data,
   input  wire [7:0]  cmd_wdata,
   output reg         cmd_ack_r,
   output reg         rd_valid_r,
   output reg  [7:0]  rd_data_r,
   // Converter side
   input  wire        en_pin,
   input  wire        addr_done,
   input  wire        fault_shutdown,
   input  wire [3:0]  fault_cond,
   output reg         converter_enable_r,
   output reg         latched_off_r,
   output reg         margin_low_r,
   output reg         margin_high_r,
   output reg         margin_act_on_fault_r,
   // Status and alert line (open drain, active low)
   output wire [4:0]  fault_flags,
   output wire        alert_o,
   output wire        alert_oe
);

   // ==========================================================
   // Helper functions

   // Byte read back from the enable source configuration
   function [7:0] config_view;
      input [7:0] stored;
      begin
         config_view = (stored & `CONFIG_KEEP) | `CONFIG_FIXED_ONES;
      end
   endfunction

   // True for the four defined lock codes
   function lock_code_ok;
      input [7:0] value;
      begin
         lock_code_ok = (value == `LOCK_ALL) || (value == `LOCK_ALLOW_RUN) ||
                        (value == `LOCK_ALLOW_RUN_CFG) || (value == `LOCK_NONE);
      end
   endfunction

   // True for codes this block answers
   function code_known;
      input [7:0] code;
      begin
         if (code == `CODE_RUN_MARGIN) begin
            code_known = 1'b1;
         end else if (code == `CODE_ENABLE_CONFIG) begin
            code_known = 1'b1;
         end else if (code == `CODE_CLEAR_FAULTS) begin
            code_known = 1'b1;
         end else if (code == `CODE_WRITE_LOCK) begin
            code_known = 1'b1;
         end else begin
            code_known = 1'b0;
         end
      end
   endfunction

   // ==========================================================
   // Register state
   reg  [7:0]  run_margin_r;
   reg  [7:0]  run_margin_nxt;
   reg  [7:0]  config_r;
   reg  [7:0]  config_nxt;
   reg  [7:0]  lock_r;
   reg  [7:0]  lock_nxt;

   // ==========================================================
   // Decode results
   reg  [7:0]  rd_data_nxt;
   reg         rd_valid_nxt;
   reg         cmd_ack_nxt;
   reg         clear_pulse;
   reg         comm_fault;

   wire        write_allowed;
   wire        is_write;
   wire [3:0]  margin_sel;
   wire        alert_w;

   assign is_write   = cmd_valid && !cmd_read && cmd_has_data;
   assign margin_sel = run_margin_r[`MARGIN_HI:`MARGIN_LO];

   // ==========================================================
   // Write permission
   write_gate u_write_gate (
      .lock_level (lock_r),
      .code       (cmd_code),
      .allowed    (write_allowed)
   );

   // ==========================================================
   // Command decode
   always @* begin
      run_margin_nxt = run_margin_r;
      config_nxt     = config_r;
      lock_nxt       = lock_r;
      rd_data_nxt    = rd_data_r;
      rd_valid_nxt   = 1'b0;
      cmd_ack_nxt    = 1'b0;
      clear_pulse    = 1'b0;
      comm_fault     = 1'b0;
      if (cmd_valid) begin
         // Every byte is acknowledged, even when ignored
         cmd_ack_nxt = 1'b1;
         if (!code_known(cmd_code)) begin
            comm_fault = 1'b1;
            if (cmd_read) begin
               rd_data_nxt  = 8'h00;
               rd_valid_nxt = 1'b1;
            end
         end else if (cmd_read) begin
            // Unsupported bits were never stored, so they read as zero, except config bits four, one and zero, which read one
            rd_valid_nxt = 1'b1;
            if (cmd_code == `CODE_RUN_MARGIN) begin
               rd_data_nxt = run_margin_r;
            end else if (cmd_code == `CODE_ENABLE_CONFIG) begin
               rd_data_nxt = config_view(config_r);
            end else if (cmd_code == `CODE_WRITE_LOCK) begin
               rd_data_nxt = lock_r;
            end else begin
               // Clear-faults is send-byte only; nothing to read
               rd_data_nxt = 8'h00;
               comm_fault  = 1'b1;
            end
         end else if (cmd_code == `CODE_CLEAR_FAULTS) begin
            // Send-byte only; a trailing data byte makes it malformed
            if (cmd_has_data) begin
               comm_fault = 1'b1;
            end else begin
               clear_pulse = 1'b1;
            end
         end else if (!is_write) begin
            // Byte registers need a data byte
            comm_fault = 1'b1;
         end else if (write_allowed) begin
            // A refused write never gets here: acknowledged, nothing stored
            if (cmd_code == `CODE_RUN_MARGIN) begin
               run_margin_nxt = cmd_wdata & `RUN_MARGIN_KEEP;
            end else if (cmd_code == `CODE_ENABLE_CONFIG) begin
               config_nxt = config_view(cmd_wdata);
            end else if (lock_code_ok(cmd_wdata)) begin
               lock_nxt = cmd_wdata;
            end else begin
               // Undefined lock codes are faulty data; the level stays as it was
               comm_fault = 1'b1;
            end
         end
         // A blocked write leaves every register as it was
      end
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         run_margin_r <= `RUN_MARGIN_RESET;
         config_r     <= `CONFIG_RESET;
         lock_r       <= `LOCK_RESET;
      end else begin
         run_margin_r <= run_margin_nxt;
         config_r     <= config_nxt;
         lock_r       <= lock_nxt;
      end
   end

   // ==========================================================
   // Command answer
   // Registered, so the front end always sees the answer one cycle after the byte
   always @(posedge core_clk) begin
      if (!rst_n) begin
         rd_data_r    <= 8'h00;
         rd_valid_r   <= 1'b0;
         cmd_ack_r    <= 1'b0;
      end else begin
         rd_data_r    <= rd_data_nxt;
         rd_valid_r   <= rd_valid_nxt;
         cmd_ack_r    <= cmd_ack_nxt;
      end
   end

   // ==========================================================
   // Margin select
   // Outputs are registered, so they follow the field one cycle later, two cycles after a write
   reg margin_low_nxt;
   reg margin_high_nxt;
   reg margin_act_nxt;

   always @* begin
      margin_low_nxt  = 1'b0;
      margin_high_nxt = 1'b0;
      margin_act_nxt  = 1'b0;
      // Undefined patterns, like 00xx, leave margining off
      case (margin_sel)
         `MARGIN_LOW_IGNORE: begin
            margin_low_nxt = 1'b1;
         end
         `MARGIN_LOW_ACT: begin
            margin_low_nxt = 1'b1;
            margin_act_nxt = 1'b1;
         end
         `MARGIN_HIGH_IGNORE: begin
            margin_high_nxt = 1'b1;
         end
         `MARGIN_HIGH_ACT: begin
            margin_high_nxt = 1'b1;
            margin_act_nxt  = 1'b1;
         end
         default: begin
            margin_low_nxt  = 1'b0;
            margin_high_nxt = 1'b0;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         margin_low_r          <= 1'b0;
         margin_high_r         <= 1'b0;
         margin_act_on_fault_r <= 1'b0;
      end else begin
         margin_low_r          <= margin_low_nxt;
         margin_high_r         <= margin_high_nxt;
         margin_act_on_fault_r <= margin_act_nxt;
      end
   end

   // ==========================================================
   // Enable source selection
   reg  enable_req;
   wire use_cmd;
   wire use_pin;
   wire run_bit;

   assign use_cmd = config_r[`CMD_USE_BIT];
   assign use_pin = config_r[`PIN_USE_BIT];
   assign run_bit = run_margin_r[`RUN_BIT];

   always @* begin
      case ({use_cmd, use_pin})
         2'b01: begin
            // Pin alone; the run bit is stored but has no effect
            enable_req = en_pin;
         end
         2'b10: begin
            enable_req = run_bit;
         end
         2'b11: begin
            // Both sources must agree before the switcher runs
            enable_req = run_bit && en_pin;
         end
         default: begin
            // Neither source: only address detection gates the start
            enable_req = addr_done;
         end
      endcase
   end

   // ==========================================================
   // Fault latch-off and restart
   // Only an off request or a reset clears the latch-off, so the next on is a restart;
   // clear-faults has no path into this logic on purpose.
   // In auto mode only addr_done low counts as an off request.
   reg latched_off_nxt;

   always @* begin
      latched_off_nxt = latched_off_r;
      if (!enable_req) begin
         latched_off_nxt = 1'b0;
      end
      if (fault_shutdown) begin
         latched_off_nxt = 1'b1;
      end
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         // Power cycle releases the latch-off
         latched_off_r      <= 1'b0;
         converter_enable_r <= 1'b0;
      end else begin
         latched_off_r      <= latched_off_nxt;
         converter_enable_r <= enable_req && !latched_off_nxt;
      end
   end

   // ==========================================================
   // Status flags and alert
   // The host should only clear while alert is active; an idle clear is harmless.
   fault_latch u_fault_latch (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .fault_set ({comm_fault, fault_cond}),
      .clear     (clear_pulse),
      .flags_r   (fault_flags),
      .alert_r   (alert_w)
   );

   // ==========================================================
   // Alert pin
   // Open drain: the pad pulls low while enabled and floats otherwise,
   // so alert_o is constant and only the enable carries the state
   assign alert_o  = 1'b0;
   assign alert_oe = alert_w;

endmodule // pmbus_onoff_protect_regs
`default_nettype wire

// ---- testbench/pmbus_onoff_protect_regs_assertions.sv ----
// Purpose: Port-level checks on the on/off, margin and write-lock block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none
module pmbus_onoff_protect_regs_assertions (
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic       cmd_read,
   input wire logic       cmd_has_data,
   input wire logic       cmd_ack_r,
   input wire logic       rd_valid_r,
   input wire logic       fault_shutdown,
   input wire logic [3:0] fault_cond,
   input wire logic       converter_enable_r,
   input wire logic       latched_off_r,
   input wire logic       margin_low_r,
   input wire logic       margin_high_r,
   input wire logic [4:0] fault_flags,
   input wire logic       alert_oe
);
   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire logic clr_cmd = cmd_valid && !cmd_read && !cmd_has_data && cmd_code == 8'h03;

   chk_ack_each_cmd: assert property (cmd_valid |=> cmd_ack_r && rd_valid_r == $past(cmd_read))
      else $error("command not answered one cycle later");
   chk_no_stray_ack: assert property (!cmd_valid |=> !cmd_ack_r && !rd_valid_r)
      else $error("answer without a command");
   chk_alert_follows: assert property (alert_oe == (|fault_flags))
      else $error("alert differs from latched flags");
   chk_flag_sets: assert property (fault_cond != 4'h0 |=>
      (fault_flags[3:0] & $past(fault_cond)) == $past(fault_cond) && alert_oe)
      else $error("fault condition not latched");
   chk_clear_all: assert property (clr_cmd && fault_cond == 4'h0 |=> fault_flags == 5'h00 && !alert_oe)
      else $error("clear left flags or alert set");
   chk_shutdown_latch: assert property (fault_shutdown |=> latched_off_r && !converter_enable_r)
      else $error("shutdown did not latch off");
   chk_latched_quiet: assert property (latched_off_r |-> !converter_enable_r)
      else $error("converter runs while latched off");
   chk_margin_excl: assert property (!(margin_low_r && margin_high_r))
      else $error("both margin directions on");
   chk_unknown_comm: assert property (cmd_valid && cmd_code == 8'h55 |=> fault_flags[4])
      else $error("unknown code did not flag");

   cover property (clr_cmd ##1 alert_oe);
   cover property (fault_shutdown ##1 latched_off_r);
   cover property (cmd_valid && cmd_read ##1 rd_valid_r);
endmodule // pmbus_onoff_protect_regs_assertions

bind pmbus_onoff_protect_regs pmbus_onoff_protect_regs_assertions u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
   .cmd_read(cmd_read), .cmd_has_data(cmd_has_data), .cmd_ack_r(cmd_ack_r),
   .rd_valid_r(rd_valid_r), .fault_shutdown(fault_shutdown), .fault_cond(fault_cond),
   .converter_enable_r(converter_enable_r), .latched_off_r(latched_off_r),
   .margin_low_r(margin_low_r), .margin_high_r(margin_high_r),
   .fault_flags(fault_flags), .alert_oe(alert_oe));
`default_nettype wire

// ---- testbench/pmbus_host_model.sv ----
// Purpose: Host side issuing decoded byte commands
// Assumes: Caller sits just after a falling edge
// Notes:   Code and data lines are scrambled once taken; read and data-present flags keep their last value
`timescale 1ns/10ps
`default_nettype none
module pmbus_host_model (
   input  wire logic       core_clk,
   output var  logic       cmd_valid,
   output var  logic [7:0] cmd_code,
   output var  logic       cmd_read,
   output var  logic       cmd_has_data,
   output var  logic [7:0] cmd_wdata,
   input  wire logic       cmd_ack_r,
   input  wire logic       rd_valid_r,
   input  wire logic [7:0] rd_data_r,
   input  wire logic       alert_oe
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'hA5;
      cmd_read = 1'b0;
      cmd_has_data = 1'b0;
      cmd_wdata = 8'h5A;
   end
   // ==========================================================
   // One command; a = answered with the right read strobe
   task automatic xfer(input logic [7:0] c, input logic r, input logic h, input logic [7:0] d,
                       output logic [7:0] q, output logic a);
      @(posedge core_clk);
      cmd_code <= c;
      cmd_read <= r;
      cmd_has_data <= h;
      cmd_wdata <= d;
      cmd_valid <= 1'b1;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
      cmd_wdata <= ~d;
      @(negedge core_clk);
      q = rd_data_r;
      a = cmd_ack_r && rd_valid_r == r;
   endtask
   // Pointless without a standing alert, so it is skipped then
   task automatic clear_faults;
      logic [7:0] q;
      logic       a;
      if (alert_oe)
         xfer(8'h03, 1'b0, 1'b0, 8'h00, q, a);
   endtask
endmodule // pmbus_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the on/off, margin and write-lock block
// Assumes: Host model drives commands, bench drives converter pins
// Notes:   Every task ends just after a falling edge
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic       core_clk, rst_n, cmd_valid, cmd_read, cmd_has_data, cmd_ack_r, rd_valid_r;
   logic [7:0] cmd_code, cmd_wdata, rd_data_r, q;
   logic       en_pin, addr_done, fault_shutdown, converter_enable_r, latched_off_r, a;
   logic       margin_low_r, margin_high_r, margin_act_on_fault_r, alert_oe;
   logic [3:0] fault_cond, m;
   logic [4:0] fault_flags;
   int         bad_count, checks;
   logic [7:0] cfgs [4] = '{8'h13, 8'h17, 8'h1B, 8'h1F};
   logic [7:0] locks [4] = '{8'h80, 8'h40, 8'h20, 8'h00};
   logic [3:0] pats [7] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h9, 4'hA, 4'hF};

   pmbus_onoff_protect_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_read(cmd_read), .cmd_has_data(cmd_has_data), .cmd_wdata(cmd_wdata),
      .cmd_ack_r(cmd_ack_r), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .en_pin(en_pin),
      .addr_done(addr_done), .fault_shutdown(fault_shutdown), .fault_cond(fault_cond),
      .converter_enable_r(converter_enable_r), .latched_off_r(latched_off_r),
      .margin_low_r(margin_low_r), .margin_high_r(margin_high_r),
      .margin_act_on_fault_r(margin_act_on_fault_r), .fault_flags(fault_flags),
      .alert_o(), .alert_oe(alert_oe));
   pmbus_host_model u_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_read(cmd_read), .cmd_has_data(cmd_has_data), .cmd_wdata(cmd_wdata),
      .cmd_ack_r(cmd_ack_r), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .alert_oe(alert_oe));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      u_host.xfer(c, 1'b0, 1'b1, d, q, a);
      chk(a, 1'b1);
   endtask
   task automatic rd(input logic [7:0] c, input logic [7:0] e);
      u_host.xfer(c, 1'b1, 1'b0, 8'h00, q, a);
      chk({a, q}, {1'b1, e});
   endtask
   task automatic pins(input logic p, input logic ad, input logic [3:0] fc, input logic sd);
      @(posedge core_clk);
      en_pin <= p;
      addr_done <= ad;
      fault_cond <= fc;
      fault_shutdown <= sd;
      @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic do_reset;
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      test_done;
   end
   // ==========================================================
   // Sequence
   initial begin
      {rst_n, en_pin, addr_done, fault_shutdown, fault_cond} = 8'h00;
      bad_count = 0;
      checks = 0;
      do_reset;
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h17);
      rd(8'h10, 8'h00);
      foreach (cfgs[i]) begin
         for (int k = 0; k < 4; k++) begin
            wr(8'h01, {k[1], 7'h00});
            pins(k[0], k[0] ^ k[1], 4'h0, 1'b0);
            wr(8'h02, cfgs[i] ^ 8'hF3);
            rd(8'h02, cfgs[i]);
            chk(converter_enable_r, cfgs[i][3] ? (cfgs[i][2] ? k[1] & k[0] : k[1])
                                                : (cfgs[i][2] ? k[0] : k[0] ^ k[1]));
         end
      end
      wr(8'h01, 8'h00);
      wr(8'h02, 8'h17);
      foreach (locks[i]) begin
         wr(8'h10, locks[i]);
         wr(8'h01, 8'h80);
         wr(8'h02, 8'h1B);
         rd(8'h10, locks[i]);
         rd(8'h01, locks[i] == 8'h80 ? 8'h00 : 8'h80);
         rd(8'h02, locks[i] inside {8'h20, 8'h00} ? 8'h1B : 8'h17);
         wr(8'h10, 8'h00);
         wr(8'h01, 8'h00);
         wr(8'h02, 8'h17);
      end
      chk(fault_flags, 5'h00);
      wr(8'h10, 8'h33);
      rd(8'h10, 8'h00);
      chk(fault_flags, 5'h10);
      u_host.clear_faults();
      chk({alert_oe, fault_flags}, 6'h00);
      pins(1'b0, 1'b0, 4'h5, 1'b0);
      chk({alert_oe, fault_flags}, 6'h25);
      u_host.clear_faults();
      chk({alert_oe, fault_flags}, 6'h25);
      pins(1'b0, 1'b0, 4'h0, 1'b0);
      u_host.clear_faults();
      chk({alert_oe, fault_flags}, 6'h00);
      rd(8'h55, 8'h00);
      // A latched condition flag shows whether the malformed clear wrongly cleared
      pins(1'b0, 1'b0, 4'h2, 1'b0);
      pins(1'b0, 1'b0, 4'h0, 1'b0);
      u_host.xfer(8'h03, 1'b0, 1'b1, 8'h00, q, a);
      chk(fault_flags, 5'h12);
      pins(1'b1, 1'b0, 4'h0, 1'b0);
      chk(converter_enable_r, 1'b1);
      pins(1'b1, 1'b0, 4'h1, 1'b1);
      chk({latched_off_r, converter_enable_r}, 2'h2);
      pins(1'b1, 1'b0, 4'h0, 1'b0);
      u_host.clear_faults();
      chk({latched_off_r, converter_enable_r, alert_oe}, 3'h4);
      pins(1'b0, 1'b0, 4'h0, 1'b0);
      pins(1'b1, 1'b0, 4'h0, 1'b0);
      chk({latched_off_r, converter_enable_r}, 2'h1);
      foreach (pats[i]) begin
         m = pats[i];
         wr(8'h01, {2'b01, m, 2'b11});
         rd(8'h01, {2'b00, m, 2'b00});
         chk(margin_low_r, m inside {4'h5, 4'h6});
         chk(margin_high_r, m inside {4'h9, 4'hA});
         chk(margin_act_on_fault_r, m inside {4'h6, 4'hA});
      end
      // Keep the enable request high so only the power cycle can release the latch
      wr(8'h01, 8'h80);
      wr(8'h02, 8'h1B);
      pins(1'b1, 1'b0, 4'h0, 1'b1);
      pins(1'b1, 1'b0, 4'h0, 1'b0);
      chk({latched_off_r, converter_enable_r}, 2'h2);
      do_reset;
      pins(1'b1, 1'b0, 4'h0, 1'b0);
      chk({latched_off_r, converter_enable_r}, 2'h1);
      rd(8'h02, 8'h17);
      rd(8'h01, 8'h00);
      test_done;
   end
endmodule // tb_top
`default_nettype wire
